// File: verilog/crcs_scanner.sv
// CRC engine with program memory scanner, reached over APB
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module crcs_scanner
   import crcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Program memory
   output crcs_mem_req_type mem_out,
   input wire crcs_mem_rsp_type mem_in,
   // CPU side
   input wire logic irq_active,
   input wire logic trigger_in,
   output logic cpu_stall
);

   crcs_state_type s_q;
   crcs_state_type s_d;

   logic wr;
   logic rd;
   logic [7:0] wb;
   logic crc_ready;
   logic go_eff;
   logic feedback;
   logic busy;
   logic fetch_ok;
   logic [15:0] next_acc;

   // --------------------------------------------------------------
   // Combinational next state
   // --------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      wr = psel && penable && pwrite && !s_q.pready;
      rd = psel && penable && !pwrite && !s_q.pready;
      wb = pwdata[7:0];
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;

      // CRC shifts one bit per cycle, MSb first into the accumulator
      crc_ready = s_q.crc_run && !s_q.full;
      feedback = s_q.acc[15] ^ s_q.shift[15];
      next_acc = {s_q.acc[14:0], 1'b0};
      if (feedback)
      begin
         next_acc = next_acc ^ (s_q.poly & POLY_KEEP);
      end
      if (s_q.crc_run && s_q.full)
      begin
         s_d.acc = next_acc;
         s_d.shift = {s_q.shift[14:0], 1'b0};
         s_d.count = s_q.count - COUNT_ONE;
         if (s_q.count == COUNT_ONE)
         begin
            s_d.full = 1'b0;
         end
      end

      // Peek ignores interrupt management
      go_eff = s_q.scan_go_a && s_q.scan_en;
      if (s_q.interrupt_management && irq_active && s_q.mode != MODE_PEEK)
      begin
         go_eff = 1'b0;
      end
      fetch_ok = go_eff && crc_ready && !s_q.invalid;
      if (s_q.mode == MODE_TRIGGERED)
      begin
         fetch_ok = fetch_ok && trigger_in;
      end
      if (s_q.mode == MODE_PEEK)
      begin
         // Peek only uses cycles in which no interrupt is active (irq_active low)
         fetch_ok = fetch_ok && !irq_active;
      end

      // Scanner sequence
      case (s_q.st)
         SC_IDLE:
         begin
            if (fetch_ok)
            begin
               s_d.mem_req = 1'b1;
               s_d.mem_addr = s_q.cur;
               s_d.st = SC_FETCH;
            end
            else if (s_q.scan_go_a && (s_q.cur > s_q.end_addr || s_q.invalid))
            begin
               s_d.scan_go_a = 1'b0;
            end
         end
         SC_FETCH:
         begin
            if (mem_in.ack)
            begin
               s_d.mem_req = 1'b0;
               s_d.shift = mem_in.data;
               s_d.full = 1'b1;
               s_d.count = SHIFT_COUNT;
               s_d.cur = s_q.cur + WORD_ONE;
               s_d.st = SC_HAND;
            end
         end
         default:
         begin
            s_d.st = SC_IDLE;
         end
      endcase
      s_d.invalid = crcs_addr_bad(s_d.cur);
      busy = (s_q.st != SC_IDLE) || (go_eff && crc_ready);
      // Burst holds the CPU for the whole scan unless interrupt management is on and an interrupt is active
      s_d.cpu_stall = (s_d.scan_go_a && s_d.scan_en && s_d.mode == MODE_BURST
         && !(s_d.interrupt_management && irq_active)) || s_d.st == SC_FETCH;

      // Register writes
      if (wr)
      begin
         s_d.pready = 1'b1;
         if (paddr == ADDR_ACC_HIGH)
         begin
            s_d.acc[15:8] = wb;
         end
         else if (paddr == ADDR_ACC_LOW)
         begin
            s_d.acc[7:0] = wb;
         end
         else if (paddr == ADDR_POLY_HIGH)
         begin
            s_d.poly[15:8] = wb;
         end
         else if (paddr == ADDR_POLY_LOW)
         begin
            s_d.poly[7:0] = {wb[7:1], 1'b0};
         end
         else if (paddr == ADDR_SCAN_CTRL)
         begin
            s_d.scan_en = wb[BIT_EN];
            s_d.interrupt_management = wb[BIT_INTERRUPT_MANAGEMENT];
            s_d.mode = crcs_mode_type'(wb[BIT_MODE_HI:BIT_MODE_LO]);
            // Set wins over the hardware clear in the same cycle
            s_d.scan_go_a = wb[BIT_GO] && wb[BIT_EN];
         end
         else if (paddr == ADDR_CUR_HIGH)
         begin
            if (!s_q.scan_go_a)
            begin
               s_d.cur[15:8] = wb;
            end
         end
         else if (paddr == ADDR_CUR_LOW)
         begin
            if (!s_q.scan_go_a)
            begin
               s_d.cur[7:0] = wb;
            end
         end
         else if (paddr == ADDR_END_HIGH)
         begin
            if (!s_q.scan_go_a)
            begin
               s_d.end_addr[15:8] = wb;
            end
         end
         else if (paddr == ADDR_END_LOW)
         begin
            if (!s_q.scan_go_a)
            begin
               s_d.end_addr[7:0] = wb;
            end
         end
         else if (paddr == ADDR_INPUT_LOW)
         begin
            s_d.shift[7:0] = wb;
            s_d.full = 1'b1;
            s_d.count = SHIFT_COUNT;
         end
         else if (paddr == ADDR_CRC_CTRL)
         begin
            s_d.crc_run = wb[BIT_CRC_RUN];
         end
         else if (paddr != ADDR_SHIFT_HIGH && paddr != ADDR_SHIFT_LOW)
         begin
            s_d.pslverr = 1'b1;
         end
         s_d.invalid = crcs_addr_bad(s_d.cur);
      end

      // Disabled scanner drops its sequence only; registers stay
      if (!s_d.scan_en)
      begin
         s_d.scan_go_a = 1'b0;
         s_d.st = SC_IDLE;
         s_d.mem_req = 1'b0;
         s_d.cpu_stall = 1'b0;
      end

      // Register reads
      if (rd)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = DATA_ZERO;
         if (paddr == ADDR_ACC_HIGH)
         begin
            s_d.prdata = crcs_rd_byte(s_q.acc[15:8]);
         end
         else if (paddr == ADDR_ACC_LOW)
         begin
            s_d.prdata = crcs_rd_byte(s_q.acc[7:0]);
         end
         else if (paddr == ADDR_SHIFT_HIGH)
         begin
            s_d.prdata = crcs_rd_byte(s_q.shift[15:8]);
         end
         else if (paddr == ADDR_SHIFT_LOW)
         begin
            s_d.prdata = crcs_rd_byte(s_q.shift[7:0]);
         end
         else if (paddr == ADDR_POLY_HIGH)
         begin
            s_d.prdata = crcs_rd_byte(s_q.poly[15:8]);
         end
         else if (paddr == ADDR_POLY_LOW)
         begin
            s_d.prdata = crcs_rd_byte({s_q.poly[7:1], 1'b0});
         end
         else if (paddr == ADDR_SCAN_CTRL)
         begin
            s_d.prdata = crcs_rd_byte({s_q.scan_en, s_q.scan_go_a, busy, s_q.invalid,
               s_q.interrupt_management, 1'b0, s_q.mode});
         end
         else if (paddr == ADDR_CUR_HIGH)
         begin
            s_d.prdata = crcs_rd_byte(s_q.cur[15:8]);
         end
         else if (paddr == ADDR_CUR_LOW)
         begin
            s_d.prdata = crcs_rd_byte(s_q.cur[7:0]);
         end
         else if (paddr == ADDR_END_HIGH)
         begin
            s_d.prdata = crcs_rd_byte(s_q.end_addr[15:8]);
         end
         else if (paddr == ADDR_END_LOW)
         begin
            s_d.prdata = crcs_rd_byte(s_q.end_addr[7:0]);
         end
         else if (paddr == ADDR_INPUT_LOW)
         begin
            s_d.prdata = crcs_rd_byte(s_q.shift[7:0]);
         end
         else if (paddr == ADDR_CRC_CTRL)
         begin
            s_d.prdata = crcs_rd_byte({7'h00, s_q.crc_run});
         end
         else
         begin
            s_d.pslverr = 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '{acc: WORD_ZERO, shift: WORD_ZERO, poly: POLY_RESET, count: COUNT_ZERO,
            full: 1'b0, crc_run: 1'b0, scan_en: 1'b0, scan_go_a: 1'b0, interrupt_management: 1'b0,
            mode: MODE_CONCURRENT, cur: WORD_ZERO, end_addr: WORD_ZERO, invalid: 1'b0,
            st: SC_IDLE, mem_req: 1'b0, mem_addr: WORD_ZERO, cpu_stall: 1'b0,
            prdata: DATA_ZERO, pready: 1'b0, pslverr: 1'b0};
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign mem_out.req = s_q.mem_req;
   assign mem_out.addr = s_q.mem_addr;
   assign cpu_stall = s_q.cpu_stall;

endmodule // crcs_scanner

// File: verilog/crcs_pkg.sv
// Package for the CRC engine with memory scanner: register map, fields, types
package crcs_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses (one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ACC_HIGH = 8'h00;
   localparam logic [7:0] ADDR_ACC_LOW = 8'h04;
   localparam logic [7:0] ADDR_SHIFT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_SHIFT_LOW = 8'h0c;
   localparam logic [7:0] ADDR_POLY_HIGH = 8'h10;
   localparam logic [7:0] ADDR_POLY_LOW = 8'h14;
   localparam logic [7:0] ADDR_SCAN_CTRL = 8'h18;
   localparam logic [7:0] ADDR_CUR_HIGH = 8'h1c;
   localparam logic [7:0] ADDR_CUR_LOW = 8'h20;
   localparam logic [7:0] ADDR_END_HIGH = 8'h24;
   localparam logic [7:0] ADDR_END_LOW = 8'h28;
   localparam logic [7:0] ADDR_INPUT_LOW = 8'h2c;
   localparam logic [7:0] ADDR_CRC_CTRL = 8'h30;

   // ----------------------------------------------------------------
   // Scanner control fields
   // ----------------------------------------------------------------
   localparam int BIT_EN = 7;
   localparam int BIT_GO = 6;
   localparam int BIT_BUSY = 5;
   localparam int BIT_INVALID = 4;
   localparam int BIT_INTERRUPT_MANAGEMENT = 3;
   localparam int BIT_MODE_HI = 1;
   localparam int BIT_MODE_LO = 0;
   // CRC control register: bit 0 enables shifting
   localparam int BIT_CRC_RUN = 0;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] WORD_ONE = 16'h0001;
   localparam logic [15:0] POLY_RESET = 16'h0000;
   localparam logic [15:0] POLY_KEEP = 16'hfffe;
   localparam logic [16:0] MEMORY_SIZE = 17'h04000;
   localparam logic [4:0] SHIFT_COUNT = 5'h10;
   localparam logic [4:0] COUNT_ZERO = 5'h00;
   localparam logic [4:0] COUNT_ONE = 5'h01;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST = 2'b01,
      MODE_PEEK = 2'b10,
      MODE_TRIGGERED = 2'b11
   } crcs_mode_type;

   typedef enum logic [1:0] {
      SC_IDLE,
      SC_FETCH,
      SC_HAND
   } crcs_scan_state_type;

   // Program memory request/answer
   typedef struct packed {
      logic req;
      logic [15:0] addr;
   } crcs_mem_req_type;

   typedef struct packed {
      logic ack;
      logic [15:0] data;
   } crcs_mem_rsp_type;

   typedef struct packed {
      logic [15:0] acc;
      logic [15:0] shift;
      logic [15:0] poly;
      logic [4:0] count;
      logic full;
      logic crc_run;
      logic scan_en;
      logic scan_go_a;
      logic interrupt_management;
      crcs_mode_type mode;
      logic [15:0] cur;
      logic [15:0] end_addr;
      logic invalid;
      crcs_scan_state_type st;
      logic mem_req;
      logic [15:0] mem_addr;
      logic cpu_stall;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } crcs_state_type;

   // True when the address lies beyond the memory
   function automatic logic crcs_addr_bad(input logic [15:0] a);
      crcs_addr_bad = ({1'b0, a} >= MEMORY_SIZE);
   endfunction

   // Zero-extend a byte onto the bus
   function automatic logic [31:0] crcs_rd_byte(input logic [7:0] b);
      crcs_rd_byte = {24'h000000, b};
   endfunction

endpackage

// File: tb/crcs_props.sv
// Port checker for the CRC scanner, bound to its top module
`timescale 1ns/1ps
module crcs_props
   import crcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Memory and CPU
   input wire crcs_mem_req_type mem_out,
   input wire crcs_mem_rsp_type mem_in,
   input wire logic irq_active,
   input wire logic trigger_in,
   input wire logic cpu_stall
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_access;
      psel && penable && !pready && clk_en;
   endsequence
   sequence s_fetch_done;
      mem_out.req && mem_in.ack && clk_en;
   endsequence
   a_apb_wait_state: assert property (s_access |=> pready)
      else $error("APB answer not one cycle after access");
   a_ready_pulse: assert property (pready && clk_en |=> !pready)
      else $error("pready longer than one cycle");
   a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_mask_bit_zero: assert property (pready && !pwrite && paddr == ADDR_POLY_LOW
      |-> !prdata[0])
      else $error("mask bit 0 reads one");
   a_unmapped_err: assert property (psel && pready && paddr > ADDR_CRC_CTRL |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (pready && paddr <= ADDR_CRC_CTRL |-> !pslverr)
      else $error("mapped access flagged as error");
   a_fetch_hold: assert property (mem_out.req && !mem_in.ack
      |=> mem_out.req && $stable(mem_out.addr))
      else $error("fetch request dropped or moved before answer");
   a_fetch_release: assert property (s_fetch_done |=> !mem_out.req)
      else $error("fetch request held after answer");
   a_addr_range: assert property (mem_out.req |-> {1'b0, mem_out.addr} < MEMORY_SIZE)
      else $error("fetch from invalid address");
endmodule // crcs_props

bind crcs_scanner crcs_props crcs_props_i (.core_clk, .rst_n, .clk_en, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_out, .mem_in, .irq_active,
   .trigger_in, .cpu_stall);

// File: tb/crcs_mem_model.sv
// Behavioural program memory answering scanner fetches
`timescale 1ns/1ps
module crcs_mem_model
   import crcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Answer delay in cycles
   input wire logic [3:0] lat,
   // Fetch port
   input wire crcs_mem_req_type mem_out,
   output crcs_mem_rsp_type mem_in
);
   // ----------------------------------------------------------------
   // Answer logic
   // ----------------------------------------------------------------
   logic [3:0] wait_q;
   // Data toggles outside answers so a stale word never looks valid
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q <= 4'h0;
         mem_in <= '0;
      end
      else if (mem_out.req && !mem_in.ack && wait_q >= lat)
      begin
         wait_q <= 4'h0;
         mem_in.ack <= 1'b1;
         mem_in.data <= mem_out.addr ^ 16'h5a3c;
      end
      else
      begin
         wait_q <= mem_out.req ? wait_q + 4'h1 : 4'h0;
         mem_in.ack <= 1'b0;
         mem_in.data <= ~mem_in.data;
      end
   end
endmodule // crcs_mem_model

// File: tb/tb.sv
// Self-checking bench for the CRC scanner over APB
`timescale 1ns/1ps
module tb
   import crcs_pkg::*;
   ;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic core_clk = 0, rst_n = 0, clk_en = 1;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cpu_stall, err;
   logic irq_active = 0, trigger_in = 0, stall_seen = 0;
   logic [3:0] lat = 4'h0;
   logic [7:0] rd;
   logic [15:0] acc_e;
   crcs_mem_req_type mem_out;
   crcs_mem_rsp_type mem_in;
   int mismatches = 0, checked = 0, fetches = 0, f0;
   logic [7:0] ra[4] = '{ADDR_ACC_HIGH, ADDR_ACC_LOW, ADDR_SHIFT_HIGH, ADDR_POLY_LOW};
   logic [7:0] rv[4] = '{8'ha5, 8'h3c, 8'h00, 8'h20};
   crcs_scanner crcs_scanner_i (.core_clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_out, .mem_in, .irq_active,
      .trigger_in, .cpu_stall);
   crcs_mem_model crcs_mem_model_i (.core_clk, .rst_n, .lat, .mem_out, .mem_in);
   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      if (mem_out.req === 1'b1 && mem_in.ack === 1'b1)
         fetches <= fetches + 1;
      // A stall with no fetch open can only come from a burst scan
      if (cpu_stall === 1'b1 && mem_out.req === 1'b0)
         stall_seen <= 1'b1;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task end_of_test;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Caller starts right after a rising edge; one idle cycle follows each transfer
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         end_of_test();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task wait_done;
      int n;
      n = 0;
      do
         apb(1'b0, ADDR_SCAN_CTRL, 8'h00);
      while (rd[BIT_GO] === 1'b1 && ++n < 60);
      chk(rd[BIT_GO], 1'b0);
      if (rd[BIT_GO] !== 1'b0)
         end_of_test();
   endtask
   task scan(input logic [15:0] cur, input logic [15:0] last, input logic [7:0] ctl);
      apb(1'b1, ADDR_CUR_HIGH, cur[15:8]);
      apb(1'b1, ADDR_CUR_LOW, cur[7:0]);
      apb(1'b1, ADDR_END_HIGH, last[15:8]);
      apb(1'b1, ADDR_END_LOW, last[7:0]);
      f0 = fetches;
      apb(1'b1, ADDR_SCAN_CTRL, ctl);
   endtask
   // MSb first; mask bit 0 is absent, so feedback only reaches the masked terms
   function automatic logic [15:0] crc(input logic [15:0] a, input logic [15:0] d);
      logic fb;
      for (int i = 15; i >= 0; i--)
      begin
         fb = a[15] ^ d[i];
         a = {a[14:0], 1'b0} ^ ({16{fb}} & 16'h1020);
      end
      return a;
   endfunction
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 11; i++)
      begin
         apb(1'b0, 8'(i * 4), 8'h00);
         chk(rd, 8'h00);
      end
      apb(1'b1, ADDR_ACC_HIGH, 8'ha5);
      apb(1'b1, ADDR_ACC_LOW, 8'h3c);
      apb(1'b1, ADDR_SHIFT_HIGH, 8'hff);
      apb(1'b1, ADDR_POLY_HIGH, 8'h10);
      apb(1'b1, ADDR_POLY_LOW, 8'h21);
      apb(1'b1, 8'h40, 8'h77);
      chk(err, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, ra[i], 8'h00);
         chk(rd, rv[i]);
      end
      apb(1'b1, ADDR_CRC_CTRL, 8'h01);
      lat <= 4'h3;
      scan(16'h3ffe, 16'h3fff, 8'hc0);
      apb(1'b1, ADDR_CUR_LOW, 8'h55);
      wait_done();
      chk(16'(fetches - f0), 16'h0002);
      repeat (18) @(posedge core_clk);
      acc_e = crc(crc(16'ha53c, 16'h3ffe ^ 16'h5a3c), 16'h3fff ^ 16'h5a3c);
      apb(1'b0, ADDR_ACC_HIGH, 8'h00);
      chk(rd, acc_e[15:8]);
      apb(1'b0, ADDR_ACC_LOW, 8'h00);
      chk(rd, acc_e[7:0]);
      apb(1'b0, ADDR_CUR_LOW, 8'h00);
      chk(rd, 8'h00);
      apb(1'b0, ADDR_SCAN_CTRL, 8'h00);
      chk(rd[BIT_INVALID], 1'b1);
      apb(1'b1, ADDR_SCAN_CTRL, 8'h00);
      apb(1'b0, ADDR_CUR_HIGH, 8'h00);
      chk(rd, 8'h40);
      lat <= 4'h0;
      for (int m = 0; m < 4; m++)
      begin
         trigger_in <= 1'b0;
         scan(16'h0000, 16'h0000, 8'hc0 | 8'(m));
         repeat (30) @(posedge core_clk);
         chk(16'(fetches - f0), (m == 3) ? 16'h0000 : 16'h0001);
         trigger_in <= 1'b1;
         wait_done();
         chk(16'(fetches - f0), 16'h0001);
      end
      chk(stall_seen, 1'b1);
      irq_active <= 1'b1;
      scan(16'h0000, 16'h0000, 8'hc8);
      repeat (30) @(posedge core_clk);
      chk(16'(fetches - f0), 16'h0000);
      apb(1'b0, ADDR_SCAN_CTRL, 8'h00);
      chk(rd[BIT_GO], 1'b1);
      irq_active <= 1'b0;
      wait_done();
      chk(16'(fetches - f0), 16'h0001);
      end_of_test();
   end
endmodule // tb
